// *** hdl/lcd_serial_pkg.sv ***
// Constants shared by the LCD serial write front end and blinker
package lcd_serial_pkg;
	typedef logic [1:0] drive_mode_t;
	localparam drive_mode_t MODE_QUAD   = 2'h0;
	localparam drive_mode_t MODE_STATIC = 2'h1;
	localparam drive_mode_t MODE_DUPLEX = 2'h2;
	localparam drive_mode_t MODE_TRI    = 2'h3;
	// Upper six bits of the seven-bit slave address
	localparam logic [5:0] ADDR_BASE     = 6'h1C;
	localparam int         CTRL_CONT_BIT = 7;
	localparam int         CTRL_RAM_BIT  = 6;
	localparam logic [3:0] OP_MODE_SET   = 4'hC;
	localparam logic [4:0] OP_DEV_SEL    = 5'h1C;
	localparam logic [5:0] OP_BANK_SEL   = 6'h3E;
	localparam logic [4:0] OP_BLINK      = 5'h1E;
	localparam int         ENABLE_BIT    = 3;
	localparam int         BIAS_BIT      = 2;
	localparam int         ALT_BIT       = 2;
	localparam int         IN_BANK_BIT   = 1;
	localparam int         OUT_BANK_BIT  = 0;
	localparam int         RATE_HI_BIT   = 1;
	localparam int         RATE_LO_BIT   = 0;
	localparam logic [11:0] BLINK_DIV_2HZ  = 12'h300;
	localparam logic [11:0] BLINK_DIV_1HZ  = 12'h600;
	localparam logic [11:0] BLINK_DIV_HALF = 12'hC00;
	localparam logic [4:0]  FRAME_DIV      = 5'h18;
	localparam drive_mode_t RST_MODE       = MODE_QUAD;
	localparam logic        RST_ENABLE     = 1'b0;
	localparam logic [1:0]  LOW_BANK_BASE  = 2'h0;
	localparam logic [1:0]  HIGH_BANK_BASE = 2'h2;
	localparam int          FIFO_WIDTH     = 10;
	localparam int          FIFO_DEPTH     = 8;
endpackage

// *** hdl/lcd_serial_front.sv ***
// Serial write slave, bank steering, blinker and display byte FIFO
`timescale 1ns/10ps
`default_nettype none

module byte_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	// Drain side
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr;
	logic [AW:0]      rdPtr;
	logic [AW:0]      next_wrPtr;
	logic [AW:0]      next_rdPtr;
	logic             doPush;
	logic             doPop;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("byte_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	always_comb begin
		inReady = (wrPtr[AW] == rdPtr[AW]) || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
		outValid = wrPtr != rdPtr;
		outData = mem[rdPtr[AW-1:0]];
		doPush = inValid && inReady;
		doPop = outValid && outReady;
		next_wrPtr = doPush ? wrPtr + 1'b1 : wrPtr;
		next_rdPtr = doPop ? rdPtr + 1'b1 : rdPtr;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (doPush) begin
			mem[wrPtr[AW-1:0]] <= inData;
		end
	end
endmodule

// Function
// - Input bank high stores data at RAM bit 2, or bits 2 and 3.
// - Storage bank and display bank are separate, independently set states.
// - Blink rate divides clock by 768, 1536, 3072, or blinking is off.
// - Alternation blink swaps displayed bank each blink phase in static/duplex.
// - Host may toggle display enable; display blanks and restores to match.
// - START is data falling, STOP data rising, both with clock high.
// - One bit per clock pulse; data change while clock high is control.
// - Addressed device holds acknowledge low across the ninth clock pulse; a display byte for a full FIFO or a wrong subaddress gets none.
// - Any number of bytes may pass between START and STOP.
// - Receive-only slave; its only bus output is acknowledge lows.
// - Answers address byte 01110000 or 01110010, picked by select pin.
// - Read requests are neither acknowledged nor answered.
// - Selection combines slave address, command data and subaddress pins.
// - Data enters on input pin; acknowledge leaves on separate open drain.
// - Blink command: mode bit, two-bit rate 00 off, 01, 10, 11.
// - Three/four-backplane modes fall back to normal whole-display blinking.
// - Mode set enable bit: 0 blanks the display, 1 enables it.
// - Bank select sets storage and display banks; ignored in tri/quad modes.
module lcd_serial_front (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	// Serial bus
	input  wire logic                   sclIn,
	input  wire logic                   sdaIn,
	output logic                        ackOutputPin,
	output logic                        ackOutputPinOe,
	// Straps
	input  wire logic                   slaveAddrSelectPin,
	input  wire logic [2:0]             hwSubaddrPins,
	// Display byte stream
	output logic      [7:0]             ramData,
	output logic      [1:0]             ramBitBase,
	output logic                        ramValid,
	input  wire logic                   ramReady,
	// Display configuration and blink state
	output lcd_serial_pkg::drive_mode_t driveMode,
	output logic                        biasHalf,
	output logic                        displayEnable,
	output logic                        storeBank,
	output logic                        outBank,
	output logic                        showBank,
	output logic                        blankNow,
	output logic                        blinkPhase
);
	import lcd_serial_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_CTRL, ST_BYTE, ST_IGNORE
	} bus_state_e;

	logic sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
	logic next_sclS2, next_sclD, next_sdaS2, next_sdaD;
	logic sclRise, sclFall, startSeen, stopSeen;
	bus_state_e state, next_state;
	logic [3:0] bitCnt, next_bitCnt;
	logic [7:0] shiftReg, next_shiftReg;
	logic ackPhase, next_ackPhase, ackDrive, next_ackDrive;
	logic ctrlCont, next_ctrlCont, ctrlRam, next_ctrlRam;
	logic byteDone, cmdStrobe, pushValid, pushReady, subMatch;
	drive_mode_t next_driveMode;
	logic next_biasHalf, next_displayEnable;
	logic next_storeBank, next_outBank;
	logic [2:0] subCount, next_subCount;
	logic blinkAlt, next_blinkAlt;
	logic [1:0] flashRateField, next_flashRateField;
	logic altCapable, alternate, frameTick;
	logic [4:0] frameCnt, next_frameCnt;
	logic [11:0] blinkCnt, next_blinkCnt;
	logic next_blinkPhase, next_showBank, next_blankNow;
	logic [1:0] bitBase;
	logic [FIFO_WIDTH-1:0] fifoOut;

	function automatic logic rate_phase(input logic [11:0] c,
			input logic [1:0] r);
		case (r)
			2'h1: rate_phase = (c % BLINK_DIV_2HZ) >= (BLINK_DIV_2HZ >> 1);
			2'h2: rate_phase = (c % BLINK_DIV_1HZ) >= (BLINK_DIV_1HZ >> 1);
			2'h3: rate_phase = c >= (BLINK_DIV_HALF >> 1);
			default: rate_phase = 1'b0;
		endcase
	endfunction

	// Line synchronisers and edge detection
	always_comb begin
		next_sclS2 = sclS1;
		next_sdaS2 = sdaS1;
		next_sclD = sclS2;
		next_sdaD = sdaS2;
		sclRise = sclS2 && !sclD;
		sclFall = !sclS2 && sclD;
		startSeen = sclS2 && sclD && sdaD && !sdaS2;
		stopSeen = sclS2 && sclD && !sdaD && sdaS2;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclS1 <= 1'b1;
			sclS2 <= 1'b1;
			sclD <= 1'b1;
			sdaS1 <= 1'b1;
			sdaS2 <= 1'b1;
			sdaD <= 1'b1;
		end else begin
			sclS1 <= sclIn;
			sclS2 <= next_sclS2;
			sclD <= next_sclD;
			sdaS1 <= sdaIn;
			sdaS2 <= next_sdaS2;
			sdaD <= next_sdaD;
		end
	end

	// Bus receiver
	always_comb begin
		next_state = state;
		next_bitCnt = bitCnt;
		next_shiftReg = shiftReg;
		next_ackPhase = ackPhase;
		next_ackDrive = ackDrive;
		next_ctrlCont = ctrlCont;
		next_ctrlRam = ctrlRam;
		byteDone = 1'b0;
		cmdStrobe = 1'b0;
		pushValid = 1'b0;
		subMatch = subCount == hwSubaddrPins;
		if (startSeen || stopSeen) begin
			next_state = startSeen ? ST_ADDR : ST_IDLE;
			next_bitCnt = 4'h0;
			next_ackPhase = 1'b0;
			next_ackDrive = 1'b0;
		end else if (state != ST_IDLE && state != ST_IGNORE) begin
			if (sclRise && !ackPhase && bitCnt < 4'h8) begin
				next_shiftReg = {shiftReg[6:0], sdaS2};
				next_bitCnt = bitCnt + 4'h1;
			end
			if (sclFall && ackPhase) begin
				next_ackPhase = 1'b0;
				next_ackDrive = 1'b0;
				next_bitCnt = 4'h0;
			end else if (sclFall && bitCnt == 4'h8) begin
				byteDone = 1'b1;
				next_ackPhase = 1'b1;
				case (state)
					ST_ADDR: begin
						// Write to our address only; reads ignored
						if (shiftReg == {ADDR_BASE, slaveAddrSelectPin,
								1'b0}) begin
							next_ackDrive = 1'b1;
							next_state = ST_CTRL;
						end else begin
							next_ackPhase = 1'b0;
							next_state = ST_IGNORE;
						end
					end
					ST_CTRL: begin
						next_ackDrive = 1'b1;
						next_ctrlCont = shiftReg[CTRL_CONT_BIT];
						next_ctrlRam = shiftReg[CTRL_RAM_BIT];
						next_state = ST_BYTE;
					end
					ST_BYTE: begin
						if (ctrlRam) begin
							pushValid = subMatch;
							next_ackDrive = subMatch && pushReady;
						end else begin
							cmdStrobe = 1'b1;
							next_ackDrive = 1'b1;
						end
						// No byte limit inside one transfer
						next_state = ctrlCont ? ST_CTRL : ST_BYTE;
					end
					default: next_state = ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			bitCnt <= 4'h0;
			shiftReg <= 8'h00;
			ackPhase <= 1'b0;
			ackDrive <= 1'b0;
			ctrlCont <= 1'b0;
			ctrlRam <= 1'b0;
		end else begin
			state <= next_state;
			bitCnt <= next_bitCnt;
			shiftReg <= next_shiftReg;
			ackPhase <= next_ackPhase;
			ackDrive <= next_ackDrive;
			ctrlCont <= next_ctrlCont;
			ctrlRam <= next_ctrlRam;
		end
	end

	// Open drain acknowledge: only ever pulls low
	assign ackOutputPin = 1'b0;
	assign ackOutputPinOe = ackDrive;

	// Command execution
	always_comb begin
		next_driveMode = driveMode;
		next_biasHalf = biasHalf;
		next_displayEnable = displayEnable;
		next_subCount = subCount;
		next_storeBank = storeBank;
		next_outBank = outBank;
		next_blinkAlt = blinkAlt;
		next_flashRateField = flashRateField;
		altCapable = driveMode == MODE_STATIC || driveMode == MODE_DUPLEX;
		if (cmdStrobe) begin
			if (shiftReg[7:4] == OP_MODE_SET) begin
				next_displayEnable = shiftReg[ENABLE_BIT];
				next_biasHalf = shiftReg[BIAS_BIT];
				next_driveMode = shiftReg[1:0];
			end else if (shiftReg[7:3] == OP_DEV_SEL) begin
				next_subCount = shiftReg[2:0];
			end else if (shiftReg[7:2] == OP_BANK_SEL) begin
				if (altCapable) begin
					next_storeBank = shiftReg[IN_BANK_BIT];
					next_outBank = shiftReg[OUT_BANK_BIT];
				end
			end else if (shiftReg[7:3] == OP_BLINK) begin
				next_blinkAlt = shiftReg[ALT_BIT];
				next_flashRateField = {shiftReg[RATE_HI_BIT],
					shiftReg[RATE_LO_BIT]};
			end
		end
		bitBase = (storeBank && altCapable) ? HIGH_BANK_BASE
			: LOW_BANK_BASE;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			driveMode <= RST_MODE;
			biasHalf <= 1'b0;
			displayEnable <= RST_ENABLE;
			subCount <= 3'h0;
			storeBank <= 1'b0;
			outBank <= 1'b0;
			blinkAlt <= 1'b0;
			flashRateField <= 2'h0;
		end else begin
			driveMode <= next_driveMode;
			biasHalf <= next_biasHalf;
			displayEnable <= next_displayEnable;
			subCount <= next_subCount;
			storeBank <= next_storeBank;
			outBank <= next_outBank;
			blinkAlt <= next_blinkAlt;
			flashRateField <= next_flashRateField;
		end
	end

	// Blinker
	always_comb begin
		frameTick = frameCnt == FRAME_DIV - 5'h1;
		next_frameCnt = frameTick ? 5'h00 : frameCnt + 5'h01;
		next_blinkCnt = (blinkCnt == BLINK_DIV_HALF - 12'h001) ? 12'h000
			: blinkCnt + 12'h001;
		next_blinkPhase = frameTick ? rate_phase(blinkCnt, flashRateField)
			: blinkPhase;
		alternate = blinkAlt && altCapable;
		next_showBank = outBank ^ (alternate && blinkPhase);
		next_blankNow = !displayEnable || (!alternate && blinkPhase);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			frameCnt <= 5'h00;
			blinkCnt <= 12'h000;
			blinkPhase <= 1'b0;
			showBank <= 1'b0;
			blankNow <= 1'b1;
		end else begin
			frameCnt <= next_frameCnt;
			blinkCnt <= next_blinkCnt;
			blinkPhase <= next_blinkPhase;
			showBank <= next_showBank;
			blankNow <= next_blankNow;
		end
	end

	byte_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk (ref_clk),
		.rst     (rst),
		.inData  ({bitBase, shiftReg}),
		.inValid (pushValid),
		.inReady (pushReady),
		.outData (fifoOut),
		.outValid(ramValid),
		.outReady(ramReady)
	);
	assign ramData = fifoOut[7:0];
	assign ramBitBase = fifoOut[9:8];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_byte_end;
		byteDone;
	endsequence
	sequence s_addr_end;
		s_byte_end ##0 state == ST_ADDR;
	endsequence

	a_start_detect: assert property (startSeen |=> state == ST_ADDR)
		else $error("start not taken");
	a_stop_idle: assert property (stopSeen |=> state == ST_IDLE)
		else $error("stop not taken");
	a_ack_release: assert property (ackOutputPinOe && ackPhase && sclFall
		&& !startSeen && !stopSeen |=> !ackOutputPinOe)
		else $error("ack held past its pulse");
	a_addr_match: assert property (s_addr_end ##0 shiftReg[7:1]
		== {ADDR_BASE, slaveAddrSelectPin} ##0 !shiftReg[0]
		|=> ackOutputPinOe && state == ST_CTRL)
		else $error("own address not acknowledged");
	a_read_refused: assert property (s_addr_end ##0 shiftReg[0]
		|=> !ackOutputPinOe && state == ST_IGNORE)
		else $error("read answered");
	a_push_subaddr: assert property (pushValid |-> subMatch
		&& state == ST_BYTE && ctrlRam)
		else $error("data stored without selection");
	a_store_bits: assert property (pushValid && storeBank && altCapable
		|-> bitBase == HIGH_BANK_BASE)
		else $error("input bank not steered");
	a_bank_locked: assert property (cmdStrobe && shiftReg[7:2]
		== OP_BANK_SEL && !altCapable |=> $stable(storeBank)
		&& $stable(outBank))
		else $error("bank select acted in tri or quad mode");
	a_alt_swap: assert property (alternate && blinkPhase
		|=> showBank != $past(outBank))
		else $error("alternate bank not shown");
	a_blank_enable: assert property (!displayEnable |=> blankNow)
		else $error("disabled display not blank");
	a_phase_frame: assert property ($changed(blinkPhase)
		|-> $past(frameTick))
		else $error("blink phase moved mid frame");
	a_ack_low_only: assert property (ackOutputPinOe
		|-> ackOutputPin == 1'b0 ##1 state != ST_IDLE || stopSeen)
		else $error("ack drive outside a transfer");
endmodule

`default_nettype wire

// *** verif/bus_master_model.sv ***
// Two-wire bus master model that drives the serial clock and data lines
`timescale 1ns/10ps
`default_nettype none

module bus_master_model (
	// Clock
	input  wire logic ref_clk,
	// Bus lines
	input  wire logic sdaWire,
	output logic      sclIn,
	output logic      sdaOut
);
	localparam int HALF = 8;

	initial begin
		sclIn = 1'b1;
		sdaOut = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic start_cond();
		// Realign to an edge so every line change lands on the clock
		tick(1);
		sdaOut <= 1'b1;
		tick(HALF);
		sclIn <= 1'b1;
		tick(HALF);
		sdaOut <= 1'b0;
		tick(HALF);
		sclIn <= 1'b0;
		tick(HALF);
	endtask

	task automatic stop_cond();
		sdaOut <= 1'b0;
		tick(HALF);
		sclIn <= 1'b1;
		tick(HALF);
		sdaOut <= 1'b1;
		tick(HALF);
	endtask

	// Eight bits MSB first, then a released ninth bit
	task automatic send_byte(input logic [7:0] b, output logic acked);
		for (int i = 7; i >= 0; i--) begin
			sdaOut <= b[i];
			tick(HALF);
			sclIn <= 1'b1;
			tick(HALF);
			sclIn <= 1'b0;
			tick(2);
		end
		sdaOut <= 1'b1;
		tick(HALF);
		sclIn <= 1'b1;
		tick(1);
		acked = !sdaWire;
		tick(HALF - 2);
		acked = acked && !sdaWire;
		tick(1);
		sclIn <= 1'b0;
		tick(HALF);
	endtask
endmodule

`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the serial write front end
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin failures++; $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module tb;
	import lcd_serial_pkg::*;
	logic        ref_clk  = 1'b0;
	logic        rst      = 1'b1;
	logic        addrSel  = 1'b0;
	logic [2:0]  subaddr  = 3'h0;
	logic        ramReady = 1'b0;
	logic        sclIn;
	logic        sdaOut;
	logic        sdaWire;
	logic        ackOutputPin;
	logic        ackOutputPinOe;
	logic [7:0]  ramData;
	logic [1:0]  ramBitBase;
	logic        ramValid;
	drive_mode_t driveMode;
	logic        biasHalf;
	logic        displayEnable;
	logic        storeBank;
	logic        outBank;
	logic        showBank;
	logic        blankNow;
	logic        blinkPhase;
	int          failures = 0;
	int          nTests   = 0;

	always #5 ref_clk = ~ref_clk;
	// Pull-up line shared by master data and open-drain acknowledge
	assign sdaWire = ackOutputPinOe ? (ackOutputPin & sdaOut) : sdaOut;

	bus_master_model bus_master_model_i (.ref_clk(ref_clk), .sdaWire(sdaWire),
		.sclIn(sclIn), .sdaOut(sdaOut));

	lcd_serial_front lcd_serial_front_i (.ref_clk(ref_clk), .rst(rst),
		.sclIn(sclIn), .sdaIn(sdaWire), .ackOutputPin(ackOutputPin),
		.ackOutputPinOe(ackOutputPinOe), .slaveAddrSelectPin(addrSel),
		.hwSubaddrPins(subaddr), .ramData(ramData), .ramBitBase(ramBitBase),
		.ramValid(ramValid), .ramReady(ramReady), .driveMode(driveMode),
		.biasHalf(biasHalf), .displayEnable(displayEnable),
		.storeBank(storeBank), .outBank(outBank), .showBank(showBank),
		.blankNow(blankNow), .blinkPhase(blinkPhase));

	task automatic complete_run();
		if (failures == 0 && nTests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic xfer(input logic [7:0] b, input logic expAck);
		logic a;
		bus_master_model_i.send_byte(b, a);
		`CHK("ack", expAck, a)
	endtask

	task automatic cmd(input logic [7:0] c);
		bus_master_model_i.start_cond();
		xfer(8'h70, 1'b1);
		xfer(8'h00, 1'b1);
		xfer(c, 1'b1);
		bus_master_model_i.stop_cond();
		tick(4);
		#1;
	endtask

	task automatic t_reset();
		`CHK("enable", 1'b0, displayEnable)
		`CHK("blank", 1'b1, blankNow)
		`CHK("ack drive", 1'b0, ackOutputPinOe)
		`CHK("ack value", 1'b0, ackOutputPin)
		`CHK("banks", 2'h0, {storeBank, outBank})
		`CHK("stream", 1'b0, ramValid)
	endtask

	task automatic t_address();
		logic [7:0] b;
		for (int s = 0; s < 2; s++) begin
			tick(1);
			addrSel <= s[0];
			for (int k = 0; k < 4; k++) begin
				b = 8'h70 + 8'(k);
				bus_master_model_i.start_cond();
				xfer(b, b == (s[0] ? 8'h72 : 8'h70));
				bus_master_model_i.stop_cond();
			end
		end
		tick(1);
		addrSel <= 1'b0;
	endtask

	task automatic t_config();
		cmd(8'hC9);
		`CHK("mode", MODE_STATIC, driveMode)
		`CHK("bias", 1'b0, biasHalf)
		`CHK("on", 2'h2, {displayEnable, blankNow})
		cmd(8'hCE);
		`CHK("mode", MODE_DUPLEX, driveMode)
		`CHK("bias", 1'b1, biasHalf)
		cmd(8'hC1);
		`CHK("blanked", 1'b1, blankNow)
		cmd(8'hC9);
		`CHK("restored", 1'b0, blankNow)
		cmd(8'hFA);
		`CHK("banks", 2'h2, {storeBank, outBank})
		cmd(8'hF9);
		`CHK("banks", 2'h1, {storeBank, outBank})
		cmd(8'hFA);
	endtask

	task automatic t_fill();
		bus_master_model_i.start_cond();
		xfer(8'h70, 1'b1);
		xfer(8'h40, 1'b1);
		for (int i = 0; i < 9; i++)
			xfer(8'hA0 + 8'(i), i < 8);
		bus_master_model_i.stop_cond();
		for (int i = 0; i < 8; i++) begin
			tick(1);
			#1;
			`CHK("valid", 1'b1, ramValid)
			`CHK("word", {2'h2, 8'hA0 + 8'(i)}, {ramBitBase, ramData})
			tick(1);
			ramReady <= 1'b1;
			tick(1);
			ramReady <= 1'b0;
		end
		tick(1);
		#1;
		`CHK("drained", 1'b0, ramValid)
	endtask

	task automatic t_subaddr();
		bus_master_model_i.start_cond();
		xfer(8'h70, 1'b1);
		xfer(8'h80, 1'b1);
		xfer(8'hE1, 1'b1);
		xfer(8'h40, 1'b1);
		xfer(8'hA5, 1'b0);
		bus_master_model_i.stop_cond();
		tick(4);
		#1;
		`CHK("not stored", 1'b0, ramValid)
		// Straps now agree with the subaddress counter
		tick(1);
		subaddr <= 3'h1;
		bus_master_model_i.start_cond();
		xfer(8'h70, 1'b1);
		xfer(8'h40, 1'b1);
		xfer(8'h3C, 1'b1);
		bus_master_model_i.stop_cond();
		tick(4);
		#1;
		`CHK("stored", 1'b1, ramValid)
		`CHK("word", {2'h2, 8'h3C}, {ramBitBase, ramData})
		tick(1);
		ramReady <= 1'b1;
		tick(1);
		ramReady <= 1'b0;
		subaddr <= 3'h0;
		cmd(8'hE0);
	endtask

	task automatic wait_rise(output int n);
		logic prev;
		n = 0;
		prev = 1'b1;
		while (n < 4000 && !(prev === 1'b0 && blinkPhase === 1'b1)) begin
			prev = blinkPhase;
			tick(1);
			#1;
			n++;
		end
		if (n >= 4000) begin
			failures++;
			complete_run();
		end
	endtask

	task automatic blink_per(input logic [7:0] code, input int per,
			input logic expBlank, input logic expShow);
		int n;
		cmd(code);
		wait_rise(n);
		wait_rise(n);
		`CHK("period", per, n)
		tick(2);
		#1;
		`CHK("blank", expBlank, blankNow)
		`CHK("shown bank", expShow, showBank)
	endtask

	task automatic t_blink();
		logic seen;
		blink_per(8'hF1, 768, 1'b1, 1'b0);
		blink_per(8'hF2, 1536, 1'b1, 1'b0);
		blink_per(8'hF3, 3072, 1'b1, 1'b0);
		blink_per(8'hF5, 768, 1'b0, 1'b1);
		cmd(8'hC8);
		cmd(8'hF9);
		`CHK("banks", 2'h2, {storeBank, outBank})
		blink_per(8'hF5, 768, 1'b1, 1'b0);
		// Host-driven segment blink: rewrite data, low bank in quad mode
		bus_master_model_i.start_cond();
		xfer(8'h70, 1'b1);
		xfer(8'h40, 1'b1);
		xfer(8'h5A, 1'b1);
		bus_master_model_i.stop_cond();
		tick(4);
		#1;
		`CHK("rewrite", {2'h0, 8'h5A}, {ramBitBase, ramData})
		tick(1);
		ramReady <= 1'b1;
		tick(1);
		ramReady <= 1'b0;
		cmd(8'hF0);
		seen = 1'b0;
		for (int i = 0; i < 3100; i++) begin
			tick(1);
			#1;
			seen = seen | blinkPhase | blankNow;
		end
		`CHK("blink off", 1'b0, seen)
	endtask

	initial begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		complete_run();
	end

	initial begin
		tick(19);
		#1;
		t_reset();
		tick(1);
		rst <= 1'b0;
		tick(4);
		t_address();
		t_config();
		t_fill();
		t_subaddr();
		t_blink();
		complete_run();
	end
endmodule

`default_nettype wire
